// [core/ncfg_map.svh]
`ifndef NCFG_MAP_SVH
`define NCFG_MAP_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define NCFG_NODE_IDX       6'h03
`define NCFG_STAT_IDX       6'h04

// ------------------------------------------------------------
// node_setup fields
// ------------------------------------------------------------
`define NCFG_DELAY_MSB      11
`define NCFG_DELAY_LSB      8
`define NCFG_BASE_MSB       7
`define NCFG_BASE_LSB       0
`define NCFG_DELAY_RST      4'h3
`define NCFG_BASE_RST       8'h00
`define NCFG_DELAY_MIN      8'h08
`define NCFG_DELAY_STEP_SH  4

// ------------------------------------------------------------
// input_and_identity_status fields
// ------------------------------------------------------------
`define NCFG_VER_MSB        31
`define NCFG_VER_LSB        24
`define NCFG_FILT_MSB       21
`define NCFG_FILT_LSB       20
`define NCFG_REV_MSB        18
`define NCFG_REV_LSB        16
`define NCFG_QSC_BIT        15
`define NCFG_LEVEL_BIT      13
`define NCFG_RES_BIT        12
`define NCFG_OSC_BIT        11
`define NCFG_ADC_BIT        9
`define NCFG_TEMP_MSB       8
`define NCFG_TEMP_LSB       1
`define NCFG_FILT_RST       2'h0
`define NCFG_LEVEL_RST      1'b1
`define NCFG_ADC_RST        1'b1
`define NCFG_TEMP_RST       8'h00
`define NCFG_PINS_RST       8'h01

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define NCFG_CLK_MHZ        25
`define NCFG_FILT_SHORT_NS  10
`define NCFG_FILT_LONG_NS   20
`define NCFG_NS_TO_CYC(ns)  (((ns) * `NCFG_CLK_MHZ + 999) / 1000)

`endif

// [core/ncfg_pkg.sv]
package ncfg_pkg;

  // Node setup register contents
  typedef struct packed {
    logic [3:0] reply_turnaround_delay;
    logic [7:0] node_base_address;
  } ncfg_node_t;

  // Writable control bits of the status word
  typedef struct packed {
    logic [1:0] serial_glitch_filter_select;
    logic       sdo_level;
    logic       temp_conv_en;
  } ncfg_ctrl_t;

  // Pin inputs from outside the clock domain
  typedef struct packed {
    logic [2:0] address_offset_pin;
    logic       interface_select_pin;
    logic       quiescence;
    logic       ref_resistor_detected;
    logic       external_osc_flag;
    logic       serial_in;
  } ncfg_pins_t;

endpackage

// [core/ncfg_sync.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Two-stage synchroniser for a bundle of levels
// ------------------------------------------------------------
module ncfg_sync #(
  parameter int           W   = 8,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;  // First stage, read only by second

  // Each bit is independent; multi-bit codes may skew by a cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      // Reset to each pin's idle level so no false edge follows reset
      meta_reg <= RST;
      o_sync   <= RST;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

// [core/ncfg_filter.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Glitch filter: output follows input once it held long enough
// ------------------------------------------------------------
module ncfg_filter #(
  parameter int CNT_W = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_raw,
  input  wire logic [CNT_W-1:0] i_len,
  output logic                  o_filt
);

  logic [CNT_W-1:0] cnt_reg;  // Cycles the input has differed

  // Length zero passes the input with one cycle of latency
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_filt  <= 1'b1;
    end else if (i_raw == o_filt) begin
      cnt_reg <= '0;
    end else if (cnt_reg >= i_len) begin
      // Stable long enough: accept the new level
      o_filt  <= i_raw;
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule

// [core/ncfg_regs.sv]
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "ncfg_map.svh"

module ncfg_regs
  #(
  parameter logic [7:0] VERSION_CODE = 8'h5A,  // Arbitrary value
  parameter logic [2:0] DIE_REV      = 3'h1,   // Arbitrary value
  parameter int         FILT_W       = 4
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic      [31:0]        o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  input  wire ncfg_pkg::ncfg_pins_t i_pins,
  input  wire logic [7:0]         i_temp_code,
  input  wire logic               i_temp_valid,
  output logic      [7:0]         o_node_addr,
  output logic      [7:0]         o_reply_bits,
  output logic                    o_serial_in_filt,
  output logic                    o_sdo,
  output logic                    o_sdo_oe,
  output logic                    o_temp_conv_en
);
  import ncfg_pkg::*;

  // ----------------------------------------------------------
  // Constants and helpers
  // ----------------------------------------------------------
  localparam logic [7:0] NODE_ADDR = {`NCFG_NODE_IDX, 2'b00};
  localparam logic [7:0] STAT_ADDR = {`NCFG_STAT_IDX, 2'b00};
  localparam int SHORT_CYC = `NCFG_NS_TO_CYC(`NCFG_FILT_SHORT_NS);
  localparam int LONG_CYC  = `NCFG_NS_TO_CYC(`NCFG_FILT_LONG_NS);

  // Turnaround in bit times: code pairs share a step of 16
  function automatic logic [7:0] delay_bits(input logic [3:0] c);
    return `NCFG_DELAY_MIN + ({1'b0, c[3:1], 4'h0});
  endfunction

  // Pin code to offset, clamped into one to six
  function automatic logic [7:0] addr_offset(input logic [2:0] c);
    logic [2:0] v;
    v = c;
    if (c == 3'h0) v = 3'h1;
    if (c == 3'h7) v = 3'h6;
    return {5'h00, v};
  endfunction

  // Filter length in cycles from the select code
  function automatic logic [FILT_W-1:0] filt_len(input logic [1:0] c);
    logic [FILT_W-1:0] n;
    n = '0;                                     // Codes 0, 1: none
    if (c == 2'h2) n = FILT_W'(SHORT_CYC);
    if (c == 2'h3) n = FILT_W'(LONG_CYC);
    return n;
  endfunction

  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  ncfg_node_t  node_reg;    // node_setup contents
  ncfg_ctrl_t  ctrl_reg;    // Writable status bits
  ncfg_pins_t  pins_s;      // Synchronised pins
  logic [7:0]  temp_reg;    // Last temperature code
  logic [31:0] stat_word;   // Live status word
  logic [31:0] node_word;   // Live node word
  logic        acc;         // Access phase
  logic        hit_node;    // Node register addressed
  logic        hit_stat;    // Status register addressed

  // ----------------------------------------------------------
  // Pin synchronisation and glitch filter
  // ----------------------------------------------------------
  // Serial input stage resets to its idle high level: a low reset
  // value would hand the filter a false edge right after reset
  ncfg_sync #(
    .W       ($bits(ncfg_pins_t)),
    .RST     (`NCFG_PINS_RST)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async (i_pins),
    .o_sync  (pins_s)
  );

  // Filter sits after the synchroniser so it sees clean levels
  ncfg_filter #(
    .CNT_W   (FILT_W)
  ) u_filt (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_raw   (pins_s.serial_in),
    .i_len   (filt_len(ctrl_reg.serial_glitch_filter_select)),
    .o_filt  (o_serial_in_filt)
  );

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------
  // Zero wait states: every access completes in its first cycle
  assign o_pready  = 1'b1;
  assign acc       = i_psel && i_penable;
  assign hit_node  = (i_paddr == NODE_ADDR);
  assign hit_stat  = (i_paddr == STAT_ADDR);
  // Unmapped addresses answer with an error and read zero
  assign o_pslverr = acc && !(hit_node || hit_stat);

  // Read views; every unlisted bit is tied low
  always_comb begin
    node_word = '0;
    node_word[`NCFG_DELAY_MSB:`NCFG_DELAY_LSB] =
      node_reg.reply_turnaround_delay;
    node_word[`NCFG_BASE_MSB:`NCFG_BASE_LSB] =
      node_reg.node_base_address;
  end

  always_comb begin
    stat_word = '0;
    stat_word[`NCFG_VER_MSB:`NCFG_VER_LSB] = VERSION_CODE;
    stat_word[`NCFG_FILT_MSB:`NCFG_FILT_LSB] =
      ctrl_reg.serial_glitch_filter_select;
    stat_word[`NCFG_REV_MSB:`NCFG_REV_LSB] = DIE_REV;
    stat_word[`NCFG_QSC_BIT]   = pins_s.quiescence;
    stat_word[`NCFG_LEVEL_BIT] = ctrl_reg.sdo_level;
    stat_word[`NCFG_RES_BIT]   = pins_s.ref_resistor_detected;
    stat_word[`NCFG_OSC_BIT]   = pins_s.external_osc_flag;
    stat_word[`NCFG_ADC_BIT]   = ctrl_reg.temp_conv_en;
    stat_word[`NCFG_TEMP_MSB:`NCFG_TEMP_LSB] = temp_reg;
  end

  // Read data is captured in the setup cycle so it leaves a flop
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= '0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      if (hit_node) begin
        o_prdata <= node_word;
      end else if (hit_stat) begin
        o_prdata <= stat_word;
      end else begin
        o_prdata <= '0;
      end
    end
  end

  // ----------------------------------------------------------
  // Node setup register
  // ----------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      node_reg.reply_turnaround_delay <= `NCFG_DELAY_RST;
      node_reg.node_base_address      <= `NCFG_BASE_RST;
    end else if (acc && i_pwrite && hit_node) begin
      node_reg.reply_turnaround_delay <=
        i_pwdata[`NCFG_DELAY_MSB:`NCFG_DELAY_LSB];
      node_reg.node_base_address <=
        i_pwdata[`NCFG_BASE_MSB:`NCFG_BASE_LSB];
    end
  end

  // ----------------------------------------------------------
  // Status word control bits
  // ----------------------------------------------------------
  // Read-only fields of the word simply drop the write data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_reg.serial_glitch_filter_select <= `NCFG_FILT_RST;
      ctrl_reg.sdo_level    <= `NCFG_LEVEL_RST;
      ctrl_reg.temp_conv_en <= `NCFG_ADC_RST;
    end else if (acc && i_pwrite && hit_stat) begin
      ctrl_reg.serial_glitch_filter_select <=
        i_pwdata[`NCFG_FILT_MSB:`NCFG_FILT_LSB];
      ctrl_reg.sdo_level    <= i_pwdata[`NCFG_LEVEL_BIT];
      ctrl_reg.temp_conv_en <= i_pwdata[`NCFG_ADC_BIT];
    end
  end

  // ----------------------------------------------------------
  // Temperature capture
  // ----------------------------------------------------------
  // A disabled converter keeps the last code rather than clearing
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      temp_reg <= `NCFG_TEMP_RST;
    end else if (i_temp_valid && ctrl_reg.temp_conv_en) begin
      temp_reg <= i_temp_code;
    end
  end

  // ----------------------------------------------------------
  // Outputs toward the serial engine and converter
  // ----------------------------------------------------------
  // Effective address wraps at 8 bits; the host keeps it in range
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_node_addr  <= '0;
      o_reply_bits <= '0;
    end else begin
      o_node_addr  <= 8'(node_reg.node_base_address +
        addr_offset(pins_s.address_offset_pin));
      o_reply_bits <= delay_bits(node_reg.reply_turnaround_delay);
    end
  end

  // Data output driven only in single-wire mode, as a static level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sdo          <= 1'b0;
      o_sdo_oe       <= 1'b0;
      o_temp_conv_en <= `NCFG_ADC_RST;
    end else begin
      o_sdo          <= ctrl_reg.sdo_level;
      o_sdo_oe       <= pins_s.interface_select_pin;
      o_temp_conv_en <= ctrl_reg.temp_conv_en;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking

  sequence s_wr_node;
    i_psel && i_penable && i_pwrite && i_paddr == NODE_ADDR;
  endsequence

  sequence s_rd_node;
    i_psel && i_penable && !i_pwrite && i_paddr == NODE_ADDR;
  endsequence

  sequence s_rd_stat;
    i_psel && i_penable && !i_pwrite && i_paddr == STAT_ADDR;
  endsequence

  property p_delay_map;
    disable iff (!i_rst_n)
    s_wr_node ##1 i_rst_n |=>
      o_reply_bits == delay_bits($past(i_pwdata[11:8], 2));
  endproperty
  a_delay_map: assert property (p_delay_map)
    else $error("reply turnaround does not follow written code");

  property p_node_reset;
    $rose(i_rst_n) |-> node_reg.node_base_address == 8'h00 &&
      node_reg.reply_turnaround_delay == 4'h3;
  endproperty
  a_node_reset: assert property (p_node_reset)
    else $error("node setup reset value wrong");

  property p_eff_addr;
    disable iff (!i_rst_n)
    i_rst_n |=> o_node_addr == 8'($past(node_reg.node_base_address) +
      addr_offset($past(pins_s.address_offset_pin)));
  endproperty
  a_eff_addr: assert property (p_eff_addr)
    else $error("effective node address wrong");

  property p_version;
    disable iff (!i_rst_n)
    ##1 s_rd_stat |-> o_prdata[31:24] == VERSION_CODE &&
      o_prdata[18:16] == DIE_REV;
  endproperty
  a_version: assert property (p_version)
    else $error("version or revision read wrong");

  property p_no_filter;
    disable iff (!i_rst_n)
    ctrl_reg.serial_glitch_filter_select[1] == 1'b0 ##1 i_rst_n |->
      o_serial_in_filt == $past(pins_s.serial_in);
  endproperty
  a_no_filter: assert property (p_no_filter)
    else $error("unfiltered serial input delayed");

  property p_filt_hold;
    disable iff (!i_rst_n)
    ctrl_reg.serial_glitch_filter_select[1] &&
      $changed(pins_s.serial_in) |=> $stable(o_serial_in_filt);
  endproperty
  a_filt_hold: assert property (p_filt_hold)
    else $error("filtered serial input passed a one-cycle change");

  property p_qsc_read;
    disable iff (!i_rst_n)
    ##1 s_rd_stat |-> o_prdata[15] == $past(pins_s.quiescence) &&
      o_prdata[12] == $past(pins_s.ref_resistor_detected);
  endproperty
  a_qsc_read: assert property (p_qsc_read)
    else $error("quiescence or resistor bit read wrong");

  property p_clk_read;
    disable iff (!i_rst_n)
    ##1 s_rd_stat |-> o_prdata[11] == $past(pins_s.external_osc_flag) &&
      o_prdata[13] == $past(ctrl_reg.sdo_level);
  endproperty
  a_clk_read: assert property (p_clk_read)
    else $error("oscillator flag or output level read wrong");

  property p_sdo_level;
    disable iff (!i_rst_n)
    i_rst_n ##1 i_rst_n |-> o_sdo_oe == $past(pins_s.interface_select_pin)
      && o_sdo == $past(ctrl_reg.sdo_level);
  endproperty
  a_sdo_level: assert property (p_sdo_level)
    else $error("next-node output level wrong");

  property p_adc_reset;
    $rose(i_rst_n) |-> ctrl_reg.temp_conv_en && ctrl_reg.sdo_level;
  endproperty
  a_adc_reset: assert property (p_adc_reset)
    else $error("converter enable reset value wrong");

  property p_temp_hold;
    disable iff (!i_rst_n)
    i_temp_valid && !ctrl_reg.temp_conv_en |=> $stable(temp_reg);
  endproperty
  a_temp_hold: assert property (p_temp_hold)
    else $error("temperature changed while converter disabled");

  property p_node_zero;
    disable iff (!i_rst_n)
    ##1 s_rd_node |-> o_prdata[31:12] == 20'h00000;
  endproperty
  a_node_zero: assert property (p_node_zero)
    else $error("unused node setup bits read nonzero");

endmodule

// [verification/ncfg_host.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// APB host standing in for the far-side controller
// ------------------------------------------------------------
module ncfg_host (
  input  wire logic        i_clk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata
);
  // Idle bus at time zero
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 8'h00;
    o_pwdata  = 32'h0000_0000;
  end

  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] addr,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err, output bit ok);
    int n;
    ok  = 1'b0;
    rd  = 32'h0000_0000;
    err = 1'b0;
    @(posedge i_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= wr;
    o_paddr   <= addr;
    o_pwdata  <= wd;
    @(posedge i_clk);
    o_penable <= 1'b1;
    // Bounded wait; the slave chooses its own latency
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge i_clk);
      if (i_pready === 1'b1) begin
        rd  = i_prdata;
        err = i_pslverr;
        ok  = 1'b1;
      end
    end
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    // Released data never shows the last value
    o_pwdata  <= ~wd;
  endtask
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Self-checking bench for the node setup and status registers
// ------------------------------------------------------------
module testbench;
  import ncfg_pkg::*;
  localparam logic [7:0] VER    = 8'hC3;  // Arbitrary value
  localparam logic [2:0] REV    = 3'h5;   // Arbitrary value
  localparam logic [7:0] A_NODE = 8'h0C;  // Node setup byte address
  localparam logic [7:0] A_STAT = 8'h10;  // Status byte address
  logic        i_clk = 1'b0;              // 25 MHz clock
  logic        i_rst_n = 1'b0;            // Synchronous reset
  ncfg_pins_t  pins = 8'h01;              // Async pin bundle
  logic [7:0]  temp_code = 8'h00;         // Converter code
  logic        temp_valid = 1'b0;         // Converter strobe
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, node_addr, reply_bits;
  logic [31:0] pwdata, prdata;
  logic        filt, sdo, sdo_oe, conv_en;
  logic [15:0] lfsr = 16'h94B0;           // Fixed seed
  logic [1:0]  m_filt;                    // Model of writable bits
  logic        m_lvl, m_adc, seen;
  logic [7:0]  m_temp, base, code;
  logic [31:0] wd;
  int          error_cnt = 0;
  int          num_checks = 0;

  always #20 i_clk = ~i_clk;

  ncfg_regs #(.VERSION_CODE(VER), .DIE_REV(REV)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_pins(pins), .i_temp_code(temp_code),
    .i_temp_valid(temp_valid), .o_node_addr(node_addr),
    .o_reply_bits(reply_bits), .o_serial_in_filt(filt),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_temp_conv_en(conv_en));

  ncfg_host i_host (
    .i_clk(i_clk), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Random word from the 16-bit shift register, one step per bit
  function automatic logic [31:0] rnd();
    logic [31:0] v;
    for (int k = 0; k < 32; k++) begin
      lfsr  = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v[k]  = lfsr[0];
    end
    return v;
  endfunction

  // Pin code 0 and 7 both clamp into the one-to-six range
  function automatic logic [7:0] offs(input logic [2:0] p);
    return (p == 3'h0) ? 8'h01 : (p == 3'h7) ? 8'h06 : {5'h00, p};
  endfunction

  // Expected status word from the model and the settled pins
  function automatic logic [31:0] exp_stat();
    return {VER, 2'h0, m_filt, 1'b0, REV, pins.quiescence, 1'b0, m_lvl,
            pins.ref_resistor_detected, pins.external_osc_flag, 1'b0,
            m_adc, m_temp, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    num_checks++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Bus access; a lost answer ends the run
  task automatic acc(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] exp_v);
    logic [31:0] r;
    logic        e;
    bit          ok;
    i_host.xfer(wr, a, d, r, e, ok);
    if (!ok) begin
      error_cnt++;
      $display("mismatch at %0t: bus timeout", $time);
      wrap_up();
    end else begin
      chk(e, (a != A_NODE && a != A_STAT));
      if (!wr) chk(r, exp_v);
    end
  endtask

  task automatic rst(input int n);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    i_rst_n <= 1'b1;
    m_filt = 2'h0;
    m_lvl  = 1'b1;
    m_adc  = 1'b1;
    m_temp = 8'h00;
    repeat (4) @(posedge i_clk);
  endtask

  // Status write with junk in read-only and reserved places
  task automatic wr_stat();
    wd = rnd();
    wd[21:20] = m_filt;
    wd[13] = m_lvl;
    wd[9] = m_adc;
    acc(1'b1, A_STAT, wd, 32'h0);
    repeat (2) @(negedge i_clk);
    chk(conv_en, m_adc);
    if (sdo_oe === 1'b1) chk(sdo, m_lvl);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst(20);
    acc(1'b0, A_NODE, 32'h0, 32'h0000_0300);
    acc(1'b0, A_STAT, 32'h0, exp_stat());
    @(negedge i_clk);
    chk(reply_bits, 8'd24);
    chk(node_addr, offs(pins.address_offset_pin));
    chk(conv_en, 1'b1);
    // Every delay code, with new offset pins each time
    for (int i = 0; i < 16; i++) begin
      @(posedge i_clk);
      pins <= 8'(rnd() | 32'h1);
      repeat (4) @(posedge i_clk);
      code = 8'(i);
      base = 8'(rnd() % 249);  // base plus offset stays below 255
      // A lone node on the line may use the two shortest codes
      wd = {20'(rnd()), code[3:0], base};
      acc(1'b1, A_NODE, wd, 32'h0);
      acc(1'b0, A_NODE, 32'h0, {20'h0, code[3:0], base});
      @(negedge i_clk);
      chk(reply_bits, 8'd8 + 8'd16 * (code >> 1));
      chk(node_addr, base + offs(pins.address_offset_pin));
      chk(sdo_oe, pins.interface_select_pin);
    end
    // Every filter code; a one-cycle glitch passes only unfiltered
    for (int c = 0; c < 4; c++) begin
      @(posedge i_clk);
      pins <= 8'(rnd() | 32'h1);
      repeat (4) @(posedge i_clk);
      m_filt = 2'(c);
      m_lvl  = 1'(rnd());
      m_adc  = 1'(rnd());
      wr_stat();
      acc(1'b0, A_STAT, 32'h0, exp_stat());
      @(posedge i_clk);
      pins.serial_in <= 1'b0;
      @(posedge i_clk);
      pins.serial_in <= 1'b1;
      seen = 1'b0;
      repeat (6) begin
        @(negedge i_clk);
        if (filt === 1'b0) seen = 1'b1;
      end
      chk(seen, c < 2);
    end
    // Temperature code kept only while the converter is enabled
    for (int t = 0; t < 4; t++) begin
      m_adc = t[0];
      wr_stat();
      @(posedge i_clk);
      code = 8'(rnd());
      temp_code  <= code;
      temp_valid <= 1'b1;
      @(posedge i_clk);
      temp_valid <= 1'b0;
      if (m_adc) m_temp = code;
      acc(1'b0, A_STAT, 32'h0, exp_stat());
    end
    // Unmapped places refuse and leave the node register untouched
    wd = {20'h0, code[3:0], base};
    // Last delay loop pass left code 15 in the node register
    acc(1'b0, A_NODE, 32'h0, {20'h0, 4'hF, base});
    acc(1'b1, A_NODE, wd, 32'h0);
    acc(1'b1, 8'h14, 32'hFFFF_FFFF, 32'h0);
    acc(1'b0, 8'h14, 32'h0, 32'h0);
    acc(1'b1, 8'h00, 32'hFFFF_FFFF, 32'h0);
    acc(1'b0, 8'hFC, 32'h0, 32'h0);
    acc(1'b0, A_NODE, 32'h0, wd);
    // Reset in mid-run restores the defaults
    rst(3);
    acc(1'b0, A_NODE, 32'h0, 32'h0000_0300);
    acc(1'b0, A_STAT, 32'h0, exp_stat());
    wrap_up();
  end
endmodule
